// ===== shared/usr_pkg.sv
`default_nettype none

package usr_pkg;

    // Register port widths.
    localparam int ADDR_W = 8;
    localparam int DATA_W = 16;

    // Register byte addresses, one 32-bit aligned word each.
    localparam logic [7:0] OFS_CONTROL      = 8'h40;
    localparam logic [7:0] OFS_INT_STATUS   = 8'h44;
    localparam logic [7:0] OFS_FRAME_NUMBER = 8'h48;
    localparam logic [7:0] OFS_TOGGLE       = 8'h4c;
    localparam logic [7:0] OFS_BUF_TABLE    = 8'h50;

    // Control register fields; bits 8 to 15 are the interrupt masks.
    localparam int CTL_FORCE_RESET   = 0;
    localparam int CTL_POWER_DOWN    = 1;
    localparam int CTL_LOW_POWER     = 2;
    localparam int CTL_FORCE_SUSPEND = 3;
    localparam int CTL_RESUME        = 4;
    localparam logic [15:0] CTL_WR_MASK = 16'hff1f;
    localparam logic [15:0] CTL_RESET   = 16'h0003;

    // Interrupt status fields, shared with the mask positions.
    localparam int IST_EXP_FRAME = 8;
    localparam int IST_SOF       = 9;
    localparam int IST_RESET     = 10;
    localparam int IST_SUSPEND   = 11;
    localparam int IST_WAKEUP    = 12;
    localparam logic [15:0] IST_RESET_VAL = 16'h0000;

    // Frame number register: the two filtered bus line levels.
    localparam int FNR_LINE_PLUS  = 15;
    localparam int FNR_LINE_MINUS = 14;

    // Buffer table base: low three bits always zero.
    localparam logic [15:0] BTB_WR_MASK = 16'hfff8;
    localparam logic [15:0] BTB_RESET   = 16'h0000;
    localparam logic [15:0] TGL_RESET   = 16'h0000;

    // Timing figures and derived cycle counts.
    localparam int CLK_PERIOD_NS  = 25;
    localparam int FRAME_NS       = 1000000;
    localparam int FRAME_CYC      = FRAME_NS / CLK_PERIOD_NS;
    localparam int FILTER_NS      = 70;
    localparam int FILTER_CYC     = (FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int BUS_RESET_NS   = 2500;
    localparam int BUS_RESET_CYC  = (BUS_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [1:0] MISSED_FRAMES = 2'h3;

endpackage : usr_pkg

`default_nettype wire

// ===== src/usr_line_filter.sv
`timescale 1ns/1ps
`default_nettype none

module usr_line_filter #(
    parameter int   STABLE_CYC  = 3,
    parameter logic RESET_LEVEL = 1'b0
) (
    // Clock, reset and enable.
    input  wire logic i_sys_clk,
    input  wire logic i_rst_n,
    input  wire logic i_clk_en,
    // Raw pin and filtered level.
    input  wire logic i_pin,
    output logic      o_level
);

    localparam int CW = $clog2(STABLE_CYC + 1);

    logic          sync1_ff;
    logic          sync2_ff;
    logic          sync3_ff;
    logic [CW-1:0] stable_ff;
    logic          level_ff;
    logic          agree;
    logic          differs;
    logic [CW-1:0] nxt_stable;

    // A change counts only when the second and third stages agree.
    assign agree      = (sync2_ff == sync3_ff);
    assign differs    = agree && (sync3_ff != level_ff);
    assign nxt_stable = differs ? (stable_ff + CW'(1)) : '0;

    // Synchroniser chain and glitch filter.
    always_ff @(posedge i_sys_clk)
    begin
        if (!i_rst_n)
        begin
            sync1_ff  <= RESET_LEVEL;
            sync2_ff  <= RESET_LEVEL;
            sync3_ff  <= RESET_LEVEL;
            stable_ff <= '0;
            level_ff  <= RESET_LEVEL;
        end
        else if (i_clk_en)
        begin
            sync1_ff <= i_pin;
            sync2_ff <= sync1_ff;
            sync3_ff <= sync2_ff;
            if (differs && (stable_ff == CW'(STABLE_CYC - 1)))
            begin
                level_ff  <= sync3_ff;
                stable_ff <= '0;
            end
            else
            begin
                stable_ff <= nxt_stable;
            end
        end
    end

    assign o_level = level_ff;

endmodule : usr_line_filter

`default_nettype wire

// ===== src/usr_frame_timer.sv
`timescale 1ns/1ps
`default_nettype none

module usr_frame_timer #(
    parameter int PERIOD_CYC = 40000
) (
    // Clock, reset and enable.
    input  wire logic i_sys_clk,
    input  wire logic i_rst_n,
    input  wire logic i_clk_en,
    // Restart and period tick.
    input  wire logic i_restart,
    output logic      o_tick
);

    localparam int CW = $clog2(PERIOD_CYC);

    logic [CW-1:0] count_ff;
    logic          tick_ff;
    logic          at_end;

    assign at_end = (count_ff == CW'(PERIOD_CYC - 1));

    // Counts one frame period; a restart realigns it to the bus frame.
    always_ff @(posedge i_sys_clk)
    begin
        if (!i_rst_n)
        begin
            count_ff <= '0;
            tick_ff  <= 1'b0;
        end
        else if (i_clk_en)
        begin
            tick_ff <= at_end && !i_restart;
            if (i_restart || at_end)
            begin
                count_ff <= '0;
            end
            else
            begin
                count_ff <= count_ff + CW'(1);
            end
        end
    end

    assign o_tick = tick_ff;

endmodule : usr_frame_timer

`default_nettype wire

// ===== src/usr_suspend_resume.sv
`timescale 1ns/1ps
`default_nettype none

module usr_suspend_resume #(
    parameter int FRAME_CYC = usr_pkg::FRAME_CYC
) (
    // Clock, reset and enable.
    input  wire logic                      i_sys_clk,
    input  wire logic                      i_rst_n,
    input  wire logic                      i_clk_en,
    // Register port.
    input  wire logic [usr_pkg::ADDR_W-1:0] i_addr,
    input  wire logic [usr_pkg::DATA_W-1:0] i_wdata,
    input  wire logic                      i_wr,
    input  wire logic                      i_rd,
    output logic      [usr_pkg::DATA_W-1:0] o_rdata,
    // Bus line pins and packet engine event.
    input  wire logic                      i_line_plus_level,
    input  wire logic                      i_line_minus_level,
    input  wire logic                      i_sof_rcvd,
    // Transceiver and core control.
    output logic                           o_xcvr_low_power,
    output logic                           o_xcvr_power_down,
    output logic                           o_suspended,
    output logic                           o_resume_drive,
    output logic                           o_core_reset,
    output logic      [usr_pkg::DATA_W-1:0] o_buffer_table_base,
    output logic      [usr_pkg::DATA_W-1:0] o_toggle_bits,
    // Interrupt request.
    output logic                           o_irq
);

    localparam int RCW = $clog2(usr_pkg::BUS_RESET_CYC + 1);

    ////////////////////////////////////////////////////////////////////////////
    // Declarations.

    logic [15:0]    ctrl_ff;
    logic           lp_ff;
    logic [15:0]    status_ff;
    logic [15:0]    btable_ff;
    logic [15:0]    toggle_ff;
    logic [15:0]    rdata_ff;
    logic [1:0]     missed_ff;
    logic [RCW-1:0] se0_cnt_ff;
    logic           bus_reset_ff;
    logic           was_idle_ff;
    logic           fres_ff;

    logic           plus_f;
    logic           minus_f;
    logic           frame_tick;
    logic           wr_ctrl;
    logic           wr_status;
    logic           wr_btable;
    logic           wr_toggle;
    logic           force_suspend_bit;
    logic           line_idle;
    logic           line_se0;
    logic           lp_async_clr;
    logic           suspend_request_flag_evt;
    logic           wake_evt;
    logic           reset_evt;
    logic           fres_rise;
    logic [15:0]    set_vec;
    logic [15:0]    clr_vec;
    logic [15:0]    ctrl_view;
    logic [15:0]    fnr_view;
    logic [15:0]    rd_mux;
    logic [15:0]    nxt_status;
    logic [15:0]    nxt_ctrl;
    logic [15:0]    nxt_toggle;
    logic [15:0]    nxt_rdata;
    logic [1:0]     nxt_missed;
    logic [RCW-1:0] nxt_se0_cnt;

    ////////////////////////////////////////////////////////////////////////////
    // Line filters and frame timer.

    // Each line is synchronised and glitch filtered; idle is plus high.
    usr_line_filter #(
        .STABLE_CYC  (usr_pkg::FILTER_CYC),
        .RESET_LEVEL (1'b1)
    ) u_plus_filter (
        .i_sys_clk (i_sys_clk),
        .i_rst_n   (i_rst_n),
        .i_clk_en  (i_clk_en),
        .i_pin     (i_line_plus_level),
        .o_level   (plus_f)
    );

    usr_line_filter #(
        .STABLE_CYC  (usr_pkg::FILTER_CYC),
        .RESET_LEVEL (1'b0)
    ) u_minus_filter (
        .i_sys_clk (i_sys_clk),
        .i_rst_n   (i_rst_n),
        .i_clk_en  (i_clk_en),
        .i_pin     (i_line_minus_level),
        .o_level   (minus_f)
    );

    // The timer restarts on every received frame start, so a tick marks
    // one whole frame period with no frame start seen.
    usr_frame_timer #(
        .PERIOD_CYC (FRAME_CYC)
    ) u_frame_timer (
        .i_sys_clk (i_sys_clk),
        .i_rst_n   (i_rst_n),
        .i_clk_en  (i_clk_en),
        .i_restart (i_sof_rcvd),
        .o_tick    (frame_tick)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Address decode and event detection.

    // Word-aligned register decode.
    assign wr_ctrl   = i_wr && (i_addr == usr_pkg::OFS_CONTROL);
    assign wr_status = i_wr && (i_addr == usr_pkg::OFS_INT_STATUS);
    assign wr_btable = i_wr && (i_addr == usr_pkg::OFS_BUF_TABLE);
    assign wr_toggle = i_wr && (i_addr == usr_pkg::OFS_TOGGLE);

    // Line states and suspend-time events.
    assign force_suspend_bit     = ctrl_ff[usr_pkg::CTL_FORCE_SUSPEND];
    assign line_idle = plus_f && !minus_f;
    assign line_se0  = !plus_f && !minus_f;
    assign suspend_request_flag_evt  = frame_tick && !force_suspend_bit && (missed_ff == usr_pkg::MISSED_FRAMES - 2'h1);
    assign nxt_missed = (force_suspend_bit || i_sof_rcvd) ? 2'h0 :
                        (frame_tick && (missed_ff != usr_pkg::MISSED_FRAMES)) ?
                        missed_ff + 2'h1 : missed_ff;
    assign wake_evt  = force_suspend_bit && was_idle_ff && !line_idle;
    assign reset_evt = (bus_reset_ff && !line_se0) || fres_rise;
    assign fres_rise = ctrl_ff[usr_pkg::CTL_FORCE_RESET] && !fres_ff;
    assign nxt_se0_cnt = !line_se0 ? '0 :
                         (se0_cnt_ff == RCW'(usr_pkg::BUS_RESET_CYC)) ? se0_cnt_ff :
                         se0_cnt_ff + RCW'(1);

    // The raw pins clear low power at once while suspended, since the
    // system clock may be stopped and no synchronised view would move.
    // The flop's own output stays out of the term so the clear cannot cut itself short.
    assign lp_async_clr = force_suspend_bit && !(i_line_plus_level && !i_line_minus_level);

    ////////////////////////////////////////////////////////////////////////////
    // Next register values.

    // Hardware sets win over software clears in the same cycle.
    assign set_vec = {3'h0, wake_evt, suspend_request_flag_evt, reset_evt, i_sof_rcvd, frame_tick, 8'h00};
    assign clr_vec = wr_status ? ~i_wdata & 16'h1f00 : 16'h0000;
    assign nxt_status = set_vec | (status_ff & ~clr_vec);
    assign nxt_ctrl   = wr_ctrl ? (i_wdata & usr_pkg::CTL_WR_MASK) : ctrl_ff;
    assign nxt_toggle = wr_toggle ? (toggle_ff ^ i_wdata) : toggle_ff;

    // Read views; reserved bits read as zero.
    assign ctrl_view = {ctrl_ff[15:3], lp_ff, ctrl_ff[1:0]};
    assign fnr_view  = {plus_f, minus_f, 14'h0000};
    assign rd_mux    = (i_addr == usr_pkg::OFS_CONTROL)      ? ctrl_view :
                       (i_addr == usr_pkg::OFS_INT_STATUS)   ? status_ff :
                       (i_addr == usr_pkg::OFS_FRAME_NUMBER) ? fnr_view :
                       (i_addr == usr_pkg::OFS_TOGGLE)       ? toggle_ff :
                       (i_addr == usr_pkg::OFS_BUF_TABLE)    ? btable_ff : 16'h0000;
    assign nxt_rdata = i_rd ? rd_mux : rdata_ff;

    ////////////////////////////////////////////////////////////////////////////
    // Low-power bit with asynchronous clear on bus activity while suspended.

    always_ff @(posedge i_sys_clk or posedge lp_async_clr)
    begin
        if (lp_async_clr)
        begin
            lp_ff <= 1'b0;
        end
        else if (!i_rst_n)
        begin
            lp_ff <= usr_pkg::CTL_RESET[usr_pkg::CTL_LOW_POWER];
        end
        else if (i_clk_en && wr_ctrl)
        begin
            lp_ff <= i_wdata[usr_pkg::CTL_LOW_POWER];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Control, status and configuration registers.

    always_ff @(posedge i_sys_clk)
    begin
        if (!i_rst_n)
        begin
            ctrl_ff   <= usr_pkg::CTL_RESET;
            status_ff <= usr_pkg::IST_RESET_VAL;
            btable_ff <= usr_pkg::BTB_RESET;
            toggle_ff <= usr_pkg::TGL_RESET;
            rdata_ff  <= 16'h0000;
            fres_ff   <= usr_pkg::CTL_RESET[usr_pkg::CTL_FORCE_RESET]; // No false edge after reset.
        end
        else if (i_clk_en)
        begin
            ctrl_ff   <= nxt_ctrl;
            status_ff <= nxt_status;
            toggle_ff <= nxt_toggle;
            rdata_ff  <= nxt_rdata;
            fres_ff   <= ctrl_ff[usr_pkg::CTL_FORCE_RESET];
            if (wr_btable)
            begin
                btable_ff <= i_wdata & usr_pkg::BTB_WR_MASK;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Missed-frame, bus reset and wake trackers.

    always_ff @(posedge i_sys_clk)
    begin
        if (!i_rst_n)
        begin
            missed_ff    <= 2'h0;
            se0_cnt_ff   <= '0;
            bus_reset_ff <= 1'b0;
            was_idle_ff  <= 1'b1;
        end
        else if (i_clk_en)
        begin
            missed_ff   <= nxt_missed;
            se0_cnt_ff  <= nxt_se0_cnt;
            was_idle_ff <= line_idle;
            if (!line_se0)
            begin
                bus_reset_ff <= 1'b0;
            end
            else if (se0_cnt_ff == RCW'(usr_pkg::BUS_RESET_CYC - 1))
            begin
                bus_reset_ff <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs.

    // One request for any unmasked pending flag.
    assign o_irq = |(status_ff[15:8] & ctrl_ff[15:8]);
    assign o_rdata             = rdata_ff;
    assign o_xcvr_low_power    = lp_ff;
    assign o_xcvr_power_down   = ctrl_ff[usr_pkg::CTL_POWER_DOWN];
    assign o_suspended         = force_suspend_bit;
    assign o_resume_drive      = ctrl_ff[usr_pkg::CTL_RESUME] && force_suspend_bit;
    assign o_core_reset        = ctrl_ff[usr_pkg::CTL_FORCE_RESET] || bus_reset_ff;
    assign o_buffer_table_base = btable_ff;
    assign o_toggle_bits       = toggle_ff;

endmodule : usr_suspend_resume

`default_nettype wire

// ===== sim/usr_sr_checker.sv
`timescale 1ns/1ps
`default_nettype none

module usr_sr_checker #(
    parameter int FRAME_CYC = 50
) (
    // Clock, reset and enable.
    input wire logic        i_sys_clk,
    input wire logic        i_rst_n,
    input wire logic        i_clk_en,
    // Register port.
    input wire logic [7:0]  i_addr,
    input wire logic [15:0] i_wdata,
    input wire logic        i_wr,
    input wire logic        i_rd,
    input wire logic [15:0] o_rdata,
    // Bus lines and block outputs.
    input wire logic        i_line_plus_level,
    input wire logic        i_line_minus_level,
    input wire logic        o_xcvr_low_power,
    input wire logic        o_suspended,
    input wire logic        o_resume_drive,
    input wire logic        o_core_reset,
    input wire logic [15:0] o_buffer_table_base,
    input wire logic [15:0] o_toggle_bits,
    input wire logic        o_irq
);
    logic [7:0] se0_ff;
    logic [7:0] nxt_se0;
    wire        se0_raw;

    // Length of a raw single-ended zero, saturating so it never wraps.
    assign se0_raw = !i_line_plus_level && !i_line_minus_level;
    assign nxt_se0 = !se0_raw ? 8'h00 : se0_ff + {7'h00, se0_ff != 8'hff};
    always_ff @(posedge i_sys_clk)
    begin
        se0_ff <= i_rst_n ? nxt_se0 : 8'h00;
    end

    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (!i_rst_n);

    // A register write accepted at one address.
    sequence wr_at(logic [7:0] a);
        i_clk_en && i_wr && i_addr == a;
    endsequence
    // The raw bus sits at idle.
    sequence line_idle;
        i_line_plus_level && !i_line_minus_level;
    endsequence

    btb_write_a: assert property (
        wr_at(usr_pkg::OFS_BUF_TABLE) |=>
        o_buffer_table_base == ($past(i_wdata) & usr_pkg::BTB_WR_MASK))
        else $error("buffer table base write mismatch");
    tgl_write_a: assert property (
        wr_at(usr_pkg::OFS_TOGGLE) |=>
        o_toggle_bits == ($past(o_toggle_bits) ^ $past(i_wdata)))
        else $error("toggle bits did not invert");
    tgl_hold_a: assert property (
        !(i_clk_en && i_wr && i_addr == usr_pkg::OFS_TOGGLE) |=> $stable(o_toggle_bits))
        else $error("toggle bits moved without a write");
    force_suspend_bit_write_a: assert property (
        wr_at(usr_pkg::OFS_CONTROL) |=> o_suspended == $past(i_wdata[3]))
        else $error("force suspend write mismatch");
    lp_write_a: assert property (
        wr_at(usr_pkg::OFS_CONTROL) ##0 line_idle ##1 line_idle
        |-> o_xcvr_low_power == $past(i_wdata[2]))
        else $error("low power write mismatch");
    lp_async_a: assert property (
        o_suspended && !(i_line_plus_level && !i_line_minus_level) |-> !o_xcvr_low_power)
        else $error("low power kept during bus activity");
    mask_off_a: assert property (
        wr_at(usr_pkg::OFS_CONTROL) ##0 i_wdata[15:8] == 8'h00 |=> !o_irq)
        else $error("interrupt with all masks clear");
    rd_unmap_a: assert property (
        i_clk_en && i_rd && i_addr[7:4] != 4'h4 && i_addr != 8'h50 |=> o_rdata == 16'h0000)
        else $error("unmapped read not zero");
    bus_reset_a: assert property (
        se0_ff == 8'd120 |-> o_core_reset)
        else $error("held bus reset not detected");
    resume_gate_a: assert property (
        o_resume_drive |-> o_suspended)
        else $error("resume driven outside suspend");
endmodule : usr_sr_checker

bind usr_suspend_resume usr_sr_checker #(.FRAME_CYC(FRAME_CYC)) u_chk (
    .i_sys_clk(i_sys_clk),
    .i_rst_n(i_rst_n),
    .i_clk_en(i_clk_en),
    .i_addr(i_addr),
    .i_wdata(i_wdata),
    .i_wr(i_wr),
    .i_rd(i_rd),
    .o_rdata(o_rdata),
    .i_line_plus_level(i_line_plus_level),
    .i_line_minus_level(i_line_minus_level),
    .o_xcvr_low_power(o_xcvr_low_power),
    .o_suspended(o_suspended),
    .o_resume_drive(o_resume_drive),
    .o_core_reset(o_core_reset),
    .o_buffer_table_base(o_buffer_table_base),
    .o_toggle_bits(o_toggle_bits),
    .o_irq(o_irq)
);

`default_nettype wire

// ===== sim/usr_host_model.sv
`timescale 1ns/1ps
`default_nettype none

module usr_host_model #(
    parameter int SOF_GAP = 20
) (
    // Clock and reset.
    input  wire logic       i_sys_clk,
    input  wire logic       i_rst_n,
    // Line state: 0 idle, 1 resume, 2 bus reset, 3 illegal noise.
    input  wire logic [1:0] i_mode,
    input  wire logic       i_sof_on,
    // Bus lines and frame start event.
    output logic            o_line_plus_level,
    output logic            o_line_minus_level,
    output logic            o_sof_rcvd
);
    logic [7:0] gap_ff;

    // Lines follow the requested state; frames only go out on an idle bus.
    assign o_line_plus_level  = i_mode == 2'h0 || i_mode == 2'h3;
    assign o_line_minus_level = i_mode[0];
    assign o_sof_rcvd         = i_sof_on && gap_ff == 8'h00 && i_mode == 2'h0;

    // Frame spacing counter; it leaves reset past zero so that the first
    // frame start falls well after reset.
    always_ff @(posedge i_sys_clk)
    begin
        gap_ff <= !i_rst_n ? 8'h01 :
                  (gap_ff == SOF_GAP[7:0] - 8'h01) ? 8'h00 : gap_ff + 8'h01;
    end
endmodule : usr_host_model

`default_nettype wire

// ===== sim/testbench.sv
`timescale 1ns/1ps
`default_nettype none

module testbench;
    localparam int FC = 50;
    logic        clk    = 1'b0;
    logic        rst_n  = 1'b0;
    logic [7:0]  addr   = 8'h00;
    logic [15:0] wdata  = 16'h0000;
    logic        wr     = 1'b0;
    logic        rd     = 1'b0;
    logic [1:0]  mode   = 2'h0;
    logic        sof_on = 1'b1;
    logic        en     = 1'b1;
    logic [15:0] rdata;
    logic [15:0] d;
    wire         lp, lm, sof, lowp, pdwn, suspend_request_flag, resd, crst, irq;
    wire  [15:0] btb, tgl;
    int          bad_count = 0;
    int          compares  = 0;
    int          cyc       = 0;

    usr_suspend_resume #(.FRAME_CYC(FC)) uut (
        .i_sys_clk(clk), .i_rst_n(rst_n), .i_clk_en(en),
        .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
        .i_line_plus_level(lp), .i_line_minus_level(lm), .i_sof_rcvd(sof),
        .o_xcvr_low_power(lowp), .o_xcvr_power_down(pdwn), .o_suspended(suspend_request_flag),
        .o_resume_drive(resd), .o_core_reset(crst), .o_buffer_table_base(btb),
        .o_toggle_bits(tgl), .o_irq(irq));
    usr_host_model #(.SOF_GAP(20)) u_host (
        .i_sys_clk(clk), .i_rst_n(rst_n), .i_mode(mode), .i_sof_on(sof_on),
        .o_line_plus_level(lp), .o_line_minus_level(lm), .o_sof_rcvd(sof));

    // Clock and a ceiling on run length.
    always #12.5 clk = ~clk;
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 10000)
        begin
            bad_count++;
            give_verdict();
        end
    end

    ////////////////////////////////////////////////////////////////
    // Comparison, bus cycles and waits.
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        compares++;
        if (g !== e)
        begin
            bad_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk
    task automatic wr_reg(input logic [7:0] a, input logic [15:0] v);
        @(posedge clk);
        addr  <= a;
        wdata <= v;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
        #1;
    endtask : wr_reg
    task automatic rd_reg(input logic [7:0] a);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        #1;
        d = rdata;
    endtask : rd_reg
    task automatic wait_irq(input int n);
        for (int i = 0; i < n && irq !== 1'b1; i++)
            @(posedge clk);
        chk({15'h0000, irq}, 16'h0001);
    endtask : wait_irq
    task automatic idle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : idle

    ////////////////////////////////////////////////////////////////
    // Scenarios.
    task automatic t_regs;
        chk({15'h0000, pdwn}, 16'h0001);
        rd_reg(usr_pkg::OFS_CONTROL);
        chk(d, usr_pkg::CTL_RESET);
        rd_reg(usr_pkg::OFS_INT_STATUS);
        chk(d, usr_pkg::IST_RESET_VAL);
        rd_reg(usr_pkg::OFS_FRAME_NUMBER);
        chk(d, 16'h8000);
        rd_reg(8'h60);
        chk(d, 16'h0000);
        wr_reg(usr_pkg::OFS_BUF_TABLE, 16'hffff);
        rd_reg(usr_pkg::OFS_BUF_TABLE);
        chk(d, 16'hfff8);
        chk(btb, 16'hfff8);
        wr_reg(usr_pkg::OFS_TOGGLE, 16'h00ff);
        wr_reg(usr_pkg::OFS_TOGGLE, 16'h000f);
        // A write while the clock enable is low must leave every bit alone.
        en <= 1'b0;
        wr_reg(usr_pkg::OFS_TOGGLE, 16'hffff);
        en <= 1'b1;
        rd_reg(usr_pkg::OFS_TOGGLE);
        chk(d, 16'h00f0);
        chk(tgl, 16'h00f0);
        wr_reg(usr_pkg::OFS_CONTROL, 16'h0000);
        chk({15'h0000, pdwn}, 16'h0000);
    endtask : t_regs
    task automatic t_frames;
        wr_reg(usr_pkg::OFS_CONTROL, 16'h0900);
        wr_reg(usr_pkg::OFS_INT_STATUS, 16'h0000);
        idle(4 * FC);
        chk({15'h0000, irq}, 16'h0000);
        sof_on <= 1'b0;
        wr_reg(usr_pkg::OFS_INT_STATUS, 16'h0000);
        wait_irq(FC + 10);
        wr_reg(usr_pkg::OFS_CONTROL, 16'h0800);
        wait_irq(3 * FC + 20);
        wr_reg(usr_pkg::OFS_INT_STATUS, 16'hf7ff);
        rd_reg(usr_pkg::OFS_INT_STATUS);
        chk(d & 16'h1900, 16'h0100);
        chk({15'h0000, irq}, 16'h0000);
    endtask : t_frames
    task automatic t_suspend;
        sof_on <= 1'b1;
        wr_reg(usr_pkg::OFS_CONTROL, 16'h1808);
        chk({15'h0000, suspend_request_flag}, 16'h0001);
        wr_reg(usr_pkg::OFS_INT_STATUS, 16'h0000);
        // Frame starts seen after force suspend must not rearm the detection.
        idle(FC);
        sof_on <= 1'b0;
        idle(4 * FC);
        chk({15'h0000, irq}, 16'h0000);
        mode <= 2'h1;
        @(posedge clk);
        mode <= 2'h0;
        idle(20);
        chk({15'h0000, irq}, 16'h0000);
        wr_reg(usr_pkg::OFS_CONTROL, 16'h180c);
        chk({15'h0000, lowp}, 16'h0001);
        mode <= 2'h1;
        #1;
        chk({15'h0000, lowp}, 16'h0000);
        wait_irq(30);
        rd_reg(usr_pkg::OFS_FRAME_NUMBER);
        chk(d, 16'h4000);
        mode <= 2'h3;
        idle(20);
        rd_reg(usr_pkg::OFS_FRAME_NUMBER);
        chk(d, 16'hc000);
        mode <= 2'h0;
        idle(20);
        wr_reg(usr_pkg::OFS_CONTROL, 16'h180c);
        wr_reg(usr_pkg::OFS_CONTROL, 16'h1808);
        chk({15'h0000, lowp}, 16'h0000);
        wr_reg(usr_pkg::OFS_CONTROL, 16'h0818);
        chk({15'h0000, resd}, 16'h0001);
        idle(2 * FC);
        wr_reg(usr_pkg::OFS_CONTROL, 16'h0008);
        chk({15'h0000, resd}, 16'h0000);
    endtask : t_suspend
    task automatic t_bus_reset;
        wr_reg(usr_pkg::OFS_CONTROL, 16'h0408);
        wr_reg(usr_pkg::OFS_INT_STATUS, 16'h0000);
        mode <= 2'h2;
        idle(130);
        chk({15'h0000, crst}, 16'h0001);
        rd_reg(usr_pkg::OFS_FRAME_NUMBER);
        chk(d, 16'h0000);
        mode <= 2'h0;
        wait_irq(30);
        rd_reg(usr_pkg::OFS_INT_STATUS);
        chk(d & 16'h0400, 16'h0400);
        wr_reg(usr_pkg::OFS_CONTROL, 16'h0000);
    endtask : t_bus_reset

    task automatic give_verdict;
        $display("compares=%0d bad_count=%0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : give_verdict

    // Reset for two cycles, then the scenarios in turn.
    initial
    begin
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        t_regs();
        t_frames();
        t_suspend();
        t_bus_reset();
        give_verdict();
    end
endmodule : testbench

`default_nettype wire
